/* File: core/tds_pkg.sv */
/*
 tds_pkg: shared types and constants of the tap detect and link sleep block.
 Assumes one 100 MHz clock and an APB slave with one aligned 32-bit word per register.
*/
package tds_pkg;
   // clock rate in kHz, for deriving cycle counts
   localparam int unsigned CLK_KHZ = 100000;
   localparam int unsigned SAMPLE_W = 16;

   // three-axis sample, as it travels between modules
   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } tds_accel_t;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TAP_THR = 8'h04;
   localparam logic [7:0] OFF_TAP_MAXLEN = 8'h08;
   localparam logic [7:0] OFF_TAP_LAT = 8'h0C;
   localparam logic [7:0] OFF_TAP_WIN = 8'h10;
   localparam logic [7:0] OFF_ACT_THR = 8'h14;
   localparam logic [7:0] OFF_INACT_THR = 8'h18;
   localparam logic [7:0] OFF_INACT_TIME = 8'h1C;
   localparam logic [7:0] OFF_INT_EN = 8'h20;
   localparam logic [7:0] OFF_INT_SRC = 8'h24;
   localparam logic [7:0] OFF_INT_CLR = 8'h28;
   localparam logic [7:0] OFF_STATUS = 8'h2C;
   localparam logic [7:0] OFF_DATA_X = 8'h30;
   localparam logic [7:0] OFF_DATA_Y = 8'h34;
   localparam logic [7:0] OFF_DATA_Z = 8'h38;

   // control register layout
   localparam int unsigned CTRL_W = 10;
   localparam int unsigned CTRL_LINK = 0;
   localparam int unsigned CTRL_SLEEP_STATE_FLAG_EN = 1;
   localparam int unsigned CTRL_SPIKE_REJ = 2;
   localparam int unsigned CTRL_AXES_LO = 3;
   localparam int unsigned CTRL_RATE_LO = 6;
   localparam logic [9:0] CTRL_RST = 10'h038;

   // interrupt source / enable / clear layout
   localparam int unsigned INT_W = 5;
   localparam int unsigned INT_SINGLE = 0;
   localparam int unsigned INT_DOUBLE = 1;
   localparam int unsigned INT_ACT = 2;
   localparam int unsigned INT_INACT = 3;
   localparam int unsigned INT_DRDY = 4;
   localparam logic [4:0] INT_EN_RST = 5'h00;

   // motion event status layout
   localparam int unsigned ST_AXIS_LO = 0;
   localparam int unsigned ST_SLEEP = 3;

   // reset values of thresholds and timers (sample periods)
   localparam logic [15:0] TAP_THR_RST = 16'h0300;
   localparam logic [7:0] TAP_MAXLEN_RST = 8'h08;
   localparam logic [7:0] TAP_LAT_RST = 8'h00;
   localparam logic [7:0] TAP_WIN_RST = 8'h00;
   localparam logic [15:0] ACT_THR_RST = 16'h0100;
   localparam logic [15:0] INACT_THR_RST = 16'h0080;
   localparam logic [7:0] INACT_TIME_RST = 8'h10;

   // tap sequencer states
   typedef enum logic [2:0] {
      TAP_IDLE,
      TAP_FIRST,
      TAP_LATENCY,
      TAP_WINDOW,
      TAP_SECOND,
      TAP_QUIET
   } tds_tap_st_t;
endpackage

/* File: core/tds_decim.sv */
/*
 tds_decim: output-rate decimator with a light two-sample filter.
 Assumes raw samples arrive on pclk with a one-cycle raw_valid strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module tds_decim #(
   parameter int unsigned RATE_W = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // common raw sampling stream
   input wire tds_pkg::tds_accel_t raw_sample,
   input wire logic raw_valid,
   // decimation select, ratio is two to this power
   input wire logic [RATE_W-1:0] rate_sel,
   // decimated filtered output
   output tds_pkg::tds_accel_t out_data,
   output logic odr_tick
);
   logic [15:0] cnt_r, cnt_nxt;
   tds_pkg::tds_accel_t prev_r, prev_nxt, out_r, out_nxt;
   logic tick_nxt, tick_r;

   // mean of two samples, kept in range by the wider sum
   function automatic logic signed [15:0] avg2(input logic signed [15:0] a,
                                               input logic signed [15:0] b);
      logic signed [16:0] s;
      s = 17'(a) + 17'(b);
      return s[16:1];
   endfunction

   // one stream, every lower rate just drops samples
   always_comb begin
      cnt_nxt = cnt_r;
      prev_nxt = prev_r;
      out_nxt = out_r;
      tick_nxt = 1'b0;
      if (raw_valid) begin
         prev_nxt = raw_sample;
         if (cnt_r >= (16'h0001 << rate_sel) - 16'h0001) begin
            cnt_nxt = 16'h0000;
            tick_nxt = 1'b1;
            out_nxt.x = avg2(raw_sample.x, prev_r.x);
            out_nxt.y = avg2(raw_sample.y, prev_r.y);
            out_nxt.z = avg2(raw_sample.z, prev_r.z);
         end else begin
            cnt_nxt = cnt_r + 16'h0001;
         end
      end
   end

   // registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 16'h0000;
         prev_r <= '0;
         out_r <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         prev_r <= prev_nxt;
         out_r <= out_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign out_data = out_r;
   assign odr_tick = tick_r;
endmodule
`default_nettype wire

/* File: core/tds_core.sv */
/*
 tds_core: tap / double-tap detection, activity and inactivity with link
 operation and automatic sleep, interrupt status, and an APB register slave.
 Assumes raw samples from the sensor front end on pclk, one raw_valid per
 internal sample period; all tap and activity timers count those periods.
*/
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Function
// - reject double tap if above threshold at window start
// - reject double tap if second tap too long
// - single and double tap each need enable bit
// - each axis joins tap only if enabled
// - double tap needs non-zero latency and window
// - record first axis over threshold on tap
// - status register never cleared, only overwritten
// - detection uses raw unfiltered samples
// - lower rates come from decimating one stream
// - link mode alternates activity and inactivity
// - no auto sleep while activity event uncleared
// - sleep flag reads one while sleep_state_flag
// - single tap reported after double tap decision
// - wait latency after first tap before window
// - second tap must begin inside the window
// - spike during latency cancels pending double tap
module tds_core (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // raw sample stream, same clock domain
   input wire tds_pkg::tds_accel_t raw_sample,
   input wire logic raw_valid,
   // interrupt and sleep state
   output logic irq,
   output logic sleep_state_flag
);
   // configuration registers
   logic [tds_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [15:0] tap_threshold_level_r, tap_thr_nxt;
   logic [7:0] max_tap_duration_r, tap_maxlen_nxt;
   logic [7:0] tap_latency_time_r, tap_lat_nxt;
   logic [7:0] tap_window_r, tap_win_nxt;
   logic [15:0] act_thr_r, act_thr_nxt, inact_thr_r, inact_thr_nxt;
   logic [7:0] inact_time_r, inact_time_nxt;
   logic [tds_pkg::INT_W-1:0] int_en_r, int_en_nxt;
   // bus response
   logic [31:0] rdata_r, rdata_nxt;
   logic err_r, err_nxt;
   logic setup, access, wr_en, mapped;
   // event status
   logic [tds_pkg::INT_W-1:0] int_src_r, int_src_nxt, int_set, int_clr;
   logic [3:0] motion_event_status_reg_r, status_nxt;
   // tap sequencer
   tds_pkg::tds_tap_st_t tap_st_r, tap_st_nxt;
   logic [8:0] tap_cnt_r, tap_cnt_nxt;
   logic [2:0] first_axis_r, first_axis_nxt;
   logic [2:0] tap_above, act_above, inact_above, first_hit;
   logic tap_any, single_on, double_on, dbl_ok, spike_rej;
   logic sgl_dec, dbl_dec, single_ev, double_ev;
   // activity, inactivity, link and sleep
   logic [7:0] inact_cnt_r, inact_cnt_nxt;
   logic arm_act_r, arm_act_nxt, sleep_state_flag_r, sleep_state_flag_nxt;
   logic link_on, act_ev, inact_ev, quiet;
   // decimated data path
   tds_pkg::tds_accel_t out_data;
   logic odr_tick;
   logic signed [15:0] ax [3];

   // output data rate by decimating the single raw stream
   tds_decim #(
      .RATE_W(4)
   ) u_decim (
      .pclk(pclk),
      .presetn(presetn),
      .raw_sample(raw_sample),
      .raw_valid(raw_valid),
      .rate_sel(ctrl_r[tds_pkg::CTRL_RATE_LO +: 4]),
      .out_data(out_data),
      .odr_tick(odr_tick)
   );

   // magnitude of a two's complement sample
   function automatic logic [15:0] mag(input logic signed [15:0] s);
      return s[15] ? 16'(-s) : 16'(s);
   endfunction

   // threshold compares on raw, unfiltered samples
   assign ax[0] = raw_sample.x;
   assign ax[1] = raw_sample.y;
   assign ax[2] = raw_sample.z;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         tap_above[i] = ctrl_r[tds_pkg::CTRL_AXES_LO + i] &&
                        (mag(ax[i]) > tap_threshold_level_r);
         act_above[i] = mag(ax[i]) > act_thr_r;
         inact_above[i] = mag(ax[i]) > inact_thr_r;
      end
      // x wins a tie, then y, then z
      first_hit = tap_above[0] ? 3'h1 : (tap_above[1] ? 3'h2 : {tap_above[2], 2'b00});
   end
   assign tap_any = |tap_above;
   assign quiet = ~|inact_above;

   // apb decode; zero wait states, data registered at setup
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr_en = access && pwrite;
   assign pready = 1'b1;
   assign prdata = rdata_r;
   assign pslverr = err_r;

   always_comb begin
      case (paddr)
         tds_pkg::OFF_CTRL, tds_pkg::OFF_TAP_THR, tds_pkg::OFF_TAP_MAXLEN,
         tds_pkg::OFF_TAP_LAT, tds_pkg::OFF_TAP_WIN, tds_pkg::OFF_ACT_THR,
         tds_pkg::OFF_INACT_THR, tds_pkg::OFF_INACT_TIME, tds_pkg::OFF_INT_EN,
         tds_pkg::OFF_INT_SRC, tds_pkg::OFF_INT_CLR, tds_pkg::OFF_STATUS,
         tds_pkg::OFF_DATA_X, tds_pkg::OFF_DATA_Y, tds_pkg::OFF_DATA_Z: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // register writes and read mux
   always_comb begin
      ctrl_nxt = ctrl_r;
      tap_thr_nxt = tap_threshold_level_r;
      tap_maxlen_nxt = max_tap_duration_r;
      tap_lat_nxt = tap_latency_time_r;
      tap_win_nxt = tap_window_r;
      act_thr_nxt = act_thr_r;
      inact_thr_nxt = inact_thr_r;
      inact_time_nxt = inact_time_r;
      int_en_nxt = int_en_r;
      rdata_nxt = rdata_r;
      err_nxt = err_r;
      if (wr_en) begin
         case (paddr)
            tds_pkg::OFF_CTRL: ctrl_nxt = pwdata[tds_pkg::CTRL_W-1:0];
            tds_pkg::OFF_TAP_THR: tap_thr_nxt = pwdata[15:0];
            tds_pkg::OFF_TAP_MAXLEN: tap_maxlen_nxt = pwdata[7:0];
            tds_pkg::OFF_TAP_LAT: tap_lat_nxt = pwdata[7:0];
            tds_pkg::OFF_TAP_WIN: tap_win_nxt = pwdata[7:0];
            tds_pkg::OFF_ACT_THR: act_thr_nxt = pwdata[15:0];
            tds_pkg::OFF_INACT_THR: inact_thr_nxt = pwdata[15:0];
            tds_pkg::OFF_INACT_TIME: inact_time_nxt = pwdata[7:0];
            tds_pkg::OFF_INT_EN: int_en_nxt = pwdata[tds_pkg::INT_W-1:0];
            default: ;
         endcase
      end
      if (setup) begin
         err_nxt = !mapped;
         rdata_nxt = 32'h0000_0000;
         if (!pwrite) begin
            case (paddr)
               tds_pkg::OFF_CTRL: rdata_nxt = 32'(ctrl_r);
               tds_pkg::OFF_TAP_THR: rdata_nxt = 32'(tap_threshold_level_r);
               tds_pkg::OFF_TAP_MAXLEN: rdata_nxt = 32'(max_tap_duration_r);
               tds_pkg::OFF_TAP_LAT: rdata_nxt = 32'(tap_latency_time_r);
               tds_pkg::OFF_TAP_WIN: rdata_nxt = 32'(tap_window_r);
               tds_pkg::OFF_ACT_THR: rdata_nxt = 32'(act_thr_r);
               tds_pkg::OFF_INACT_THR: rdata_nxt = 32'(inact_thr_r);
               tds_pkg::OFF_INACT_TIME: rdata_nxt = 32'(inact_time_r);
               tds_pkg::OFF_INT_EN: rdata_nxt = 32'(int_en_r);
               tds_pkg::OFF_INT_SRC: rdata_nxt = 32'(int_src_r);
               tds_pkg::OFF_STATUS: rdata_nxt = 32'(motion_event_status_reg_r);
               tds_pkg::OFF_DATA_X: rdata_nxt = 32'(unsigned'(out_data.x));
               tds_pkg::OFF_DATA_Y: rdata_nxt = 32'(unsigned'(out_data.y));
               tds_pkg::OFF_DATA_Z: rdata_nxt = 32'(unsigned'(out_data.z));
               default: rdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= tds_pkg::CTRL_RST;
         tap_threshold_level_r <= tds_pkg::TAP_THR_RST;
         max_tap_duration_r <= tds_pkg::TAP_MAXLEN_RST;
         tap_latency_time_r <= tds_pkg::TAP_LAT_RST;
         tap_window_r <= tds_pkg::TAP_WIN_RST;
         act_thr_r <= tds_pkg::ACT_THR_RST;
         inact_thr_r <= tds_pkg::INACT_THR_RST;
         inact_time_r <= tds_pkg::INACT_TIME_RST;
         int_en_r <= tds_pkg::INT_EN_RST;
         rdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         tap_threshold_level_r <= tap_thr_nxt;
         max_tap_duration_r <= tap_maxlen_nxt;
         tap_latency_time_r <= tap_lat_nxt;
         tap_window_r <= tap_win_nxt;
         act_thr_r <= act_thr_nxt;
         inact_thr_r <= inact_thr_nxt;
         inact_time_r <= inact_time_nxt;
         int_en_r <= int_en_nxt;
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
      end
   end

   // tap sequencer enables
   assign single_on = int_en_r[tds_pkg::INT_SINGLE];
   assign double_on = int_en_r[tds_pkg::INT_DOUBLE];
   assign dbl_ok = double_on && (tap_latency_time_r != 8'h00) &&
                   (tap_window_r != 8'h00);
   assign spike_rej = ctrl_r[tds_pkg::CTRL_SPIKE_REJ];

   // tap sequencer, stepped once per raw sample
   always_comb begin
      tap_st_nxt = tap_st_r;
      tap_cnt_nxt = tap_cnt_r;
      first_axis_nxt = first_axis_r;
      sgl_dec = 1'b0;
      dbl_dec = 1'b0;
      if (!(single_on || double_on)) begin
         tap_st_nxt = tds_pkg::TAP_IDLE;
         tap_cnt_nxt = 9'h000;
      end else if (raw_valid) begin
         case (tap_st_r)
            tds_pkg::TAP_IDLE: begin
               if (tap_any) begin
                  tap_st_nxt = tds_pkg::TAP_FIRST;
                  tap_cnt_nxt = 9'h001;
                  first_axis_nxt = first_hit;
               end
            end
            tds_pkg::TAP_FIRST: begin
               if (!tap_any) begin
                  tap_cnt_nxt = 9'h000;
                  if (dbl_ok) begin
                     tap_st_nxt = tds_pkg::TAP_LATENCY;
                  end else begin
                     sgl_dec = 1'b1;
                     tap_st_nxt = tds_pkg::TAP_IDLE;
                  end
               end else if (tap_cnt_r >= {1'b0, max_tap_duration_r}) begin
                  tap_st_nxt = tds_pkg::TAP_QUIET; // too long, no tap
               end else begin
                  tap_cnt_nxt = tap_cnt_r + 9'h001;
               end
            end
            tds_pkg::TAP_LATENCY: begin
               if (tap_any && spike_rej) begin
                  sgl_dec = 1'b1;
                  tap_st_nxt = tds_pkg::TAP_QUIET;
               end else if (tap_cnt_r + 9'h001 >= {1'b0, tap_latency_time_r}) begin
                  tap_cnt_nxt = 9'h000;
                  tap_st_nxt = tds_pkg::TAP_WINDOW;
               end else begin
                  tap_cnt_nxt = tap_cnt_r + 9'h001;
               end
            end
            tds_pkg::TAP_WINDOW: begin
               if (tap_any && tap_cnt_r == 9'h000) begin
                  sgl_dec = 1'b1;
                  tap_st_nxt = tds_pkg::TAP_QUIET;
               end else if (tap_any) begin
                  tap_cnt_nxt = 9'h001;
                  tap_st_nxt = tds_pkg::TAP_SECOND;
               end else if (tap_cnt_r + 9'h001 >= {1'b0, tap_window_r}) begin
                  sgl_dec = 1'b1;
                  tap_st_nxt = tds_pkg::TAP_IDLE;
               end else begin
                  tap_cnt_nxt = tap_cnt_r + 9'h001;
               end
            end
            tds_pkg::TAP_SECOND: begin
               // second tap may run past the window end
               if (!tap_any) begin
                  sgl_dec = 1'b1;
                  dbl_dec = 1'b1;
                  tap_st_nxt = tds_pkg::TAP_IDLE;
               end else if (tap_cnt_r >= {1'b0, max_tap_duration_r}) begin
                  sgl_dec = 1'b1;
                  tap_st_nxt = tds_pkg::TAP_QUIET;
               end else begin
                  tap_cnt_nxt = tap_cnt_r + 9'h001;
               end
            end
            tds_pkg::TAP_QUIET: begin
               // wait for release so one long shock is not two taps
               if (!tap_any) begin
                  tap_st_nxt = tds_pkg::TAP_IDLE;
               end
            end
            default: tap_st_nxt = tds_pkg::TAP_IDLE;
         endcase
      end
   end
   assign single_ev = sgl_dec && single_on;
   assign double_ev = dbl_dec && double_on;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tap_st_r <= tds_pkg::TAP_IDLE;
         tap_cnt_r <= 9'h000;
         first_axis_r <= 3'h0;
      end else begin
         tap_st_r <= tap_st_nxt;
         tap_cnt_r <= tap_cnt_nxt;
         first_axis_r <= first_axis_nxt;
      end
   end

   // activity and inactivity, alternating under link
   assign link_on = ctrl_r[tds_pkg::CTRL_LINK];
   assign act_ev = raw_valid && (|act_above) && (!link_on || arm_act_r);
   assign inact_ev = raw_valid && quiet && (inact_time_r != 8'h00) &&
                     (inact_cnt_r + 8'h01 == inact_time_r) &&
                     (!link_on || !arm_act_r);

   always_comb begin
      inact_cnt_nxt = inact_cnt_r;
      arm_act_nxt = arm_act_r;
      sleep_state_flag_nxt = sleep_state_flag_r;
      if (raw_valid) begin
         if (!quiet) begin
            inact_cnt_nxt = 8'h00;
         end else if (inact_cnt_r != 8'hFF) begin
            inact_cnt_nxt = inact_cnt_r + 8'h01;
         end
      end
      if (!link_on) begin
         arm_act_nxt = 1'b0;
      end else if (act_ev) begin
         arm_act_nxt = 1'b0;
      end else if (inact_ev) begin
         arm_act_nxt = 1'b1;
      end
      // sleep needs link; held off while activity waits to be read
      if (!(link_on && ctrl_r[tds_pkg::CTRL_SLEEP_STATE_FLAG_EN]) || act_ev) begin
         sleep_state_flag_nxt = 1'b0;
      end else if (inact_ev && !int_src_r[tds_pkg::INT_ACT]) begin
         sleep_state_flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inact_cnt_r <= 8'h00;
         arm_act_r <= 1'b0;
         sleep_state_flag_r <= 1'b0;
      end else begin
         inact_cnt_r <= inact_cnt_nxt;
         arm_act_r <= arm_act_nxt;
         sleep_state_flag_r <= sleep_state_flag_nxt;
      end
   end

   // sticky sources: set wins over clear, read of source clears what was read
   assign int_set = {odr_tick, inact_ev, act_ev, double_ev, single_ev};
   always_comb begin
      int_clr = '0;
      if (access && !pwrite && paddr == tds_pkg::OFF_INT_SRC) begin
         int_clr = rdata_r[tds_pkg::INT_W-1:0];
      end else if (wr_en && paddr == tds_pkg::OFF_INT_CLR) begin
         int_clr = pwdata[tds_pkg::INT_W-1:0];
      end
      int_src_nxt = (int_src_r & ~int_clr) | int_set;
      // never cleared, only overwritten by a new tap
      status_nxt = motion_event_status_reg_r;
      if (single_ev || double_ev) begin
         status_nxt[tds_pkg::ST_AXIS_LO +: 3] = first_axis_r;
      end
      status_nxt[tds_pkg::ST_SLEEP] = sleep_state_flag_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_src_r <= '0;
         motion_event_status_reg_r <= 4'h0;
      end else begin
         int_src_r <= int_src_nxt;
         motion_event_status_reg_r <= status_nxt;
      end
   end

   assign irq = |(int_src_r & int_en_r);
   assign sleep_state_flag = sleep_state_flag_r;
endmodule
`default_nettype wire

/* File: tb/tds_core_properties.sv */
/*
 tds_core_properties: port-level checks on tds_core.
 Assumes it is bound to tds_core, with one clock, pclk, and presetn as reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tds_core_properties (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // sample stream and events
   input wire logic raw_valid,
   input wire logic irq,
   input wire logic sleep_state_flag
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_q;
   // a write can unmask a pending event, so it counts as a cause
   assign wr_q = psel && penable && pwrite;
   ready_always_a: assert property (pready) else $error("pready low");
   irq_cause_a: assert property ($rose(irq) |-> $past(raw_valid) || $past(raw_valid, 2)
      || $past(raw_valid, 3) || $past(wr_q)) else $error("irq rose without cause");
   irq_clear_a: assert property ($fell(irq) |-> $past(psel && penable))
      else $error("irq fell without host access");
   irq_hold_a: assert property (irq && !(psel && penable) |=> irq)
      else $error("irq dropped on its own");
   sleep_cause_a: assert property ($changed(sleep_state_flag) |-> $past(raw_valid)
      || $past(raw_valid, 2) || $past(raw_valid, 3) || $past(raw_valid, 4)
      || $past(wr_q) || $past(wr_q, 2))
      else $error("sleep flag moved without cause");
   err_setup_a: assert property ($rose(pslverr) |-> $past(psel) && !$past(penable))
      else $error("pslverr rose outside setup");
   err_zero_a: assert property (pslverr |-> prdata == 32'h0) else $error("error read not 0");
   idle_hold_a: assert property ((!psel)[*2] |-> $stable(prdata) && $stable(pslverr))
      else $error("read data moved while idle");
   // main scenarios reached
   cover property ($rose(irq));
   cover property ($rose(sleep_state_flag));
   cover property ($rose(pslverr));
endmodule
bind tds_core tds_core_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .raw_valid(raw_valid), .irq(irq), .sleep_state_flag(sleep_state_flag));
`default_nettype wire

/* File: tb/tds_host_model.sv */
/*
 tds_host_model: apb host that configures and services tds_core.
 Assumes callers enter its tasks just after a rising edge of pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module tds_host_model (
   // clock
   input wire logic pclk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   int tmo = 0;
   // bus idle from time zero
   initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;
   // one transfer, request held until pready seen in the access phase or 50 cycles pass
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) tmo++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // events are serviced by reading the source register
   task automatic service(output logic [31:0] q);
      logic e;
      xfer(1'b0, tds_pkg::OFF_INT_SRC, 32'h0, q, e);
   endtask
endmodule
`default_nettype wire

/* File: tb/tap_detect_and_link_sleep_tb_top.sv */
/*
 tap_detect_and_link_sleep_tb_top: self-checking bench of tds_core.
 Assumes the host model for apb; raw samples come from the bench, one per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin comparisons++; if ((g) !== (x)) begin errors++; \
   $display("wrong value %s expected %0h seen %0h", n, x, g); end end
module tap_detect_and_link_sleep_tb_top;
   typedef struct {logic [7:0] a; logic [31:0] v;} tds_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, raw_valid, irq, sleep_state_flag, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   tds_pkg::tds_accel_t raw_sample;
   int errors = 0;
   int comparisons = 0;
   // register reset values
   tds_row_t rows [10] = '{'{8'h00, 32'h38}, '{8'h04, 32'h300}, '{8'h08, 32'h8},
      '{8'h0C, 32'h0}, '{8'h10, 32'h0}, '{8'h14, 32'h100}, '{8'h18, 32'h80},
      '{8'h1C, 32'h10}, '{8'h20, 32'h0}, '{8'h2C, 32'h0}};
   tds_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   tds_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .raw_sample(raw_sample), .raw_valid(raw_valid), .irq(irq),
      .sleep_state_flag(sleep_state_flag));
   initial forever #5 pclk = ~pclk;
   task automatic complete_run();
      // a bus wait that ran out is a mismatch too
      errors += host.tmo;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, e);
   endtask
   // a hung bus ends the run at once
   task automatic rd(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0, q, e);
      if (host.tmo != 0) complete_run();
   endtask
   // n samples, 0x400 on axis ax (3 means all quiet)
   task automatic smp(input int ax, input int n);
      repeat (n) begin
         raw_sample <= {ax == 0 ? 16'h0400 : 16'h0, ax == 1 ? 16'h0400 : 16'h0,
            ax == 2 ? 16'h0400 : 16'h0};
         raw_valid <= 1'b1;
         @(posedge pclk);
      end
      raw_valid <= 1'b0;
      @(posedge pclk);
   endtask
   // first tap, q2 quiet, second tap of n2 samples, long quiet tail
   task automatic dtap(input int q2, input int n2);
      smp(0, 3);
      smp(3, q2);
      smp(0, n2);
      smp(3, 40);
   endtask
   // service the source register and compare the tap bits
   task automatic ev(input logic [1:0] x);
      host.service(q);
      `CHK("tap events", x, q[1:0])
   endtask
   initial begin
      raw_valid = 1'b0;
      raw_sample = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         rd(rows[i].a);
         `CHK("reset value", rows[i].v, q)
      end
      rd(8'h3C);
      `CHK("unmapped", 33'h100000000, {e, q})
      wr(8'h20, 32'h1);
      dtap(4, 0);
      `CHK("irq", 1'b1, irq)
      ev(2'b01);
      `CHK("irq", 1'b0, irq)
      rd(8'h2C);
      `CHK("tap axis", 3'b001, q[2:0])
      rd(8'h2C);
      `CHK("axis kept", 3'b001, q[2:0])
      wr(8'h00, 32'h10);
      dtap(4, 0);
      ev(2'b00);
      smp(1, 3);
      smp(3, 4);
      ev(2'b01);
      rd(8'h2C);
      `CHK("tap axis", 3'b010, q[2:0])
      wr(8'h00, 32'h38);
      wr(8'h20, 32'h3);
      dtap(20, 3);
      ev(2'b01);
      wr(8'h0C, 32'h11);
      wr(8'h10, 32'h11);
      dtap(20, 3);
      ev(2'b11);
      dtap(17, 3);
      ev(2'b01);
      dtap(20, 12);
      ev(2'b01);
      wr(8'h00, 32'h3C);
      smp(0, 3);
      smp(3, 5);
      dtap(14, 3);
      ev(2'b01);
      wr(8'h20, 32'h0);
      dtap(20, 3);
      ev(2'b00);
      // one raw spike trips the tap while the filtered peak stays below it
      wr(8'h20, 32'h1);
      smp(0, 1);
      smp(3, 1);
      `CHK("irq", 1'b1, irq)
      rd(8'h30);
      `CHK("filtered x", 32'h200, q)
      wr(8'h28, 32'h1F);
      `CHK("irq", 1'b0, irq)
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      wr(8'h00, 32'h3B);
      smp(0, 2);
      smp(3, 40);
      rd(8'h2C);
      `CHK("sleep_state_flag", 1'b1, q[3])
      host.service(q);
      `CHK("link order", 2'b10, q[3:2])
      smp(0, 2);
      `CHK("awake", 1'b0, sleep_state_flag)
      smp(3, 40);
      `CHK("no sleep", 1'b0, sleep_state_flag)
      complete_run();
   end
endmodule
`default_nettype wire
